/* hw/pc_card_socket_pin_mux.sv */
`timescale 1ns/1ps
`default_nettype none

module pc_card_socket_pin_mux (
    // System clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Card clock, clocks the CardBus-facing logic
    input wire logic cardClk,
    // Mode of this socket
    input wire pc_card_mux_pkg::socket_mode_t modeSel,
    // 16-bit card side, sys_clk domain
    input wire logic [25:0] pcAddr,
    input wire logic pcAddrOe,
    input wire logic [15:0] pcDataOut,
    input wire logic pcDataOe,
    output logic [15:0] pcDataIn,
    input wire logic pcAttrSel,
    input wire logic pcDma,
    input wire logic pcCe1Out,
    input wire logic pcCe1Oe,
    // CardBus side, cardClk domain
    output logic cbActive,
    input wire logic [31:0] cbAdOut,
    input wire logic cbAdOe,
    output logic [31:0] cbAdIn,
    input wire logic [3:0] cbCbeOut,
    input wire logic cbCbeOe,
    output logic [3:0] cbCbeIn,
    input wire logic [7:0] cbCtlOut,
    input wire logic [7:0] cbCtlOe,
    output logic [7:0] cbCtlIn,
    // Socket pins: attribute select / lane 3
    output logic regPinOut,
    output logic regPinOe,
    input wire logic regPinIn,
    // Socket pins: card enable 1 / lane 0
    output logic ce1PinOut,
    output logic ce1PinOe,
    input wire logic ce1PinIn,
    // Socket pins: address
    output logic [25:0] addrPinOut,
    output logic [25:0] addrPinOe,
    input wire logic [25:0] addrPinIn,
    // Socket pins: data
    output logic [15:0] dataPinOut,
    output logic [15:0] dataPinOe,
    input wire logic [15:0] dataPinIn
);

    // Build the socket pin vector from CardBus groups
    function automatic pc_card_mux_pkg::pin_vec_t cbToPins(
        input logic [31:0] ad,
        input logic [3:0] cbe,
        input logic [7:0] ctl,
        input logic clkBit,
        input logic rsvAddr,
        input logic rsvData
    );
        logic [25:0] a;
        logic [15:0] d;
        a[25] = ad[19];
        a[24] = ad[17];
        a[23] = ctl[pc_card_mux_pkg::CTL_FRAME];
        a[22] = ctl[pc_card_mux_pkg::CTL_TRDY];
        a[21] = ctl[pc_card_mux_pkg::CTL_DEVSEL];
        a[20] = ctl[pc_card_mux_pkg::CTL_STOP];
        a[19] = ctl[pc_card_mux_pkg::CTL_LOCK];
        a[18] = rsvAddr;
        a[17] = ad[16];
        a[16] = clkBit;
        a[15] = ctl[pc_card_mux_pkg::CTL_IRDY];
        a[14] = ctl[pc_card_mux_pkg::CTL_PERR];
        a[13] = ctl[pc_card_mux_pkg::CTL_PAR];
        a[12] = cbe[2];
        a[11] = ad[12];
        a[10] = ad[9];
        a[9] = ad[14];
        a[8] = cbe[1];
        a[7] = ad[18];
        for (int i = 0; i < 7; i++) begin
            a[6-i] = ad[20+i];
        end
        d = {ad[8], rsvData, ad[6], ad[4], ad[2],
            ad[31], ad[30], ad[28], ad[7], ad[5], ad[3],
            ad[1], ad[0], rsvData,
            ad[29], ad[27]};
        return {cbe[3], cbe[0], a, d};
    endfunction

    // Recover CardBus address/data from the pin vector
    function automatic logic [31:0] pinsToAd(
        input pc_card_mux_pkg::pin_vec_t p
    );
        logic [25:0] a;
        logic [15:0] d;
        logic [31:0] ad;
        a = p[pc_card_mux_pkg::PIN_ADDR_LSB +: 26];
        d = p[pc_card_mux_pkg::PIN_DATA_LSB +: 16];
        ad = '0;
        ad[19] = a[25];
        ad[17] = a[24];
        ad[16] = a[17];
        ad[12] = a[11];
        ad[9] = a[10];
        ad[14] = a[9];
        ad[18] = a[7];
        for (int i = 0; i < 7; i++) begin
            ad[20+i] = a[6-i];
        end
        ad[8] = d[15];
        {ad[6], ad[4], ad[2], ad[31], ad[30], ad[28], ad[7], ad[5], ad[3],
            ad[1], ad[0]} = d[13:3];
        {ad[29], ad[27]} = d[1:0];
        // The remaining AD bits sit on pins outside this block
        return ad;
    endfunction

    // Recover the CardBus control group from the pin vector
    function automatic logic [7:0] pinsToCtl(
        input pc_card_mux_pkg::pin_vec_t p
    );
        logic [25:0] a;
        logic [7:0] c;
        a = p[pc_card_mux_pkg::PIN_ADDR_LSB +: 26];
        c[pc_card_mux_pkg::CTL_FRAME] = a[23];
        c[pc_card_mux_pkg::CTL_TRDY] = a[22];
        c[pc_card_mux_pkg::CTL_DEVSEL] = a[21];
        c[pc_card_mux_pkg::CTL_STOP] = a[20];
        c[pc_card_mux_pkg::CTL_LOCK] = a[19];
        c[pc_card_mux_pkg::CTL_IRDY] = a[15];
        c[pc_card_mux_pkg::CTL_PERR] = a[14];
        c[pc_card_mux_pkg::CTL_PAR] = a[13];
        return c;
    endfunction

    // State of the system-clock side
    typedef struct packed {
        pc_card_mux_pkg::socket_mode_t mode;
        logic regPin;
        logic [25:0] addr;
        logic addrOe;
        logic [15:0] dataOut;
        logic dataOe;
        logic ce1Out;
        logic ce1Oe;
    } sys_state_t;

    // State of the card-clock side
    typedef struct packed {
        logic [31:0] adOut;
        logic adOe;
        logic [3:0] cbeOut;
        logic cbeOe;
        logic [7:0] ctlOut;
        logic [7:0] ctlOe;
        logic [31:0] adIn;
        logic [3:0] cbeIn;
        logic [7:0] ctlIn;
    } cb_state_t;

    sys_state_t sys;
    sys_state_t next_sys;
    cb_state_t cb;
    cb_state_t next_cb;
    logic sysCardbus;
    logic cbRstN;
    logic cbEnable;
    pc_card_mux_pkg::pin_vec_t pinIn;
    pc_card_mux_pkg::pin_vec_t cbOutPins;
    pc_card_mux_pkg::pin_vec_t cbOePins;
    pc_card_mux_pkg::pin_vec_t pcOutPins;
    pc_card_mux_pkg::pin_vec_t pcOePins;
    pc_card_mux_pkg::pin_vec_t pinOut;
    pc_card_mux_pkg::pin_vec_t pinOe;

    // System side: one registered mode steers every leg
    always_comb begin
        next_sys = sys;
        next_sys.mode = modeSel;
        next_sys.addr = pcAddr;
        next_sys.addrOe = pcAddrOe;
        next_sys.dataOut = pcDataOut;
        next_sys.dataOe = pcDataOe;
        next_sys.ce1Out = pcCe1Out;
        next_sys.ce1Oe = pcCe1Oe;
        unique case (modeSel)
            pc_card_mux_pkg::MODE_MEMORY: begin
                next_sys.regPin = ~pcAttrSel;
            end
            pc_card_mux_pkg::MODE_IO: begin
                next_sys.regPin = pcDma;
            end
            pc_card_mux_pkg::MODE_ATA: begin
                next_sys.regPin = 1'b1;
            end
            pc_card_mux_pkg::MODE_CARDBUS: begin
                next_sys.regPin = pc_card_mux_pkg::REG_PIN_RESET;
            end
        endcase
        if (!reset_n) begin
            next_sys = '0;
            next_sys.mode = pc_card_mux_pkg::MODE_RESET;
            next_sys.regPin = pc_card_mux_pkg::REG_PIN_RESET;
            next_sys.ce1Out = pc_card_mux_pkg::CE1_PIN_RESET;
        end
    end

    always_ff @(posedge sys_clk) begin
        sys <= next_sys;
    end

    assign sysCardbus = (sys.mode == pc_card_mux_pkg::MODE_CARDBUS);

    // Reset and mode level into the card clock domain
    sync_level #(
        .WIDTH(1)
    ) u_cb_reset_sync (
        .clk(cardClk),
        .rstN(1'b1),
        .d(reset_n),
        .q(cbRstN)
    );

    sync_level #(
        .WIDTH(1)
    ) u_cb_mode_sync (
        .clk(cardClk),
        .rstN(cbRstN),
        .d(sysCardbus),
        .q(cbEnable)
    );

    // Socket data pins are asynchronous to sys_clk in 16-bit mode
    sync_level #(
        .WIDTH(16)
    ) u_pc_data_sync (
        .clk(sys_clk),
        .rstN(reset_n),
        .d(dataPinIn),
        .q(pcDataIn)
    );

    assign pinIn = {regPinIn, ce1PinIn, addrPinIn, dataPinIn};

    // Card side: register drives; pins are link-synchronous, sampled once
    always_comb begin
        next_cb = cb;
        next_cb.adOut = cbAdOut;
        next_cb.adOe = cbAdOe & cbEnable;
        next_cb.cbeOut = cbCbeOut;
        next_cb.cbeOe = cbCbeOe & cbEnable;
        next_cb.ctlOut = cbCtlOut;
        next_cb.ctlOe = cbCtlOe & {8{cbEnable}};
        next_cb.adIn = pinsToAd(pinIn);
        next_cb.cbeIn = {regPinIn, addrPinIn[12], addrPinIn[8], ce1PinIn};
        next_cb.ctlIn = pinsToCtl(pinIn);
        if (!cbRstN) begin
            next_cb = '0;
        end
    end

    always_ff @(posedge cardClk) begin
        cb <= next_cb;
    end

    assign cbActive = cbEnable;
    assign cbAdIn = cb.adIn;
    assign cbCbeIn = cb.cbeIn;
    assign cbCtlIn = cb.ctlIn;

    // CardBus; output-only A16, A18 drive at once, D14 and D2 float
    assign cbOutPins = cbToPins(cb.adOut, cb.cbeOut, cb.ctlOut,
        1'b0, 1'b0, 1'b0);
    assign cbOePins = cbToPins({32{cb.adOe}}, {4{cb.cbeOe}}, cb.ctlOe,
        1'b1, 1'b1, 1'b0);

    // 16-bit personality
    assign pcOutPins = {sys.regPin, sys.ce1Out, sys.addr, sys.dataOut};
    assign pcOePins = {1'b1, sys.ce1Oe, {26{sys.addrOe}},
        {16{sys.dataOe}}};

    // Final leg select; CardBus drivers other than A16 and A18 wait for the crossed mode,
    // so a switch into CardBus breaks before it makes and no pin sees two roles
    always_comb begin
        if (sysCardbus) begin
            pinOut = cbOutPins;
            pinOut[pc_card_mux_pkg::PIN_CCLK] = cardClk;
            pinOe = cbOePins;
        end else begin
            pinOut = pcOutPins;
            pinOe = pcOePins;
        end
    end

    // Split the pin vector onto the socket ports
    assign regPinOut = pinOut[pc_card_mux_pkg::PIN_REG];
    assign regPinOe = pinOe[pc_card_mux_pkg::PIN_REG];
    assign ce1PinOut = pinOut[pc_card_mux_pkg::PIN_CE1];
    assign ce1PinOe = pinOe[pc_card_mux_pkg::PIN_CE1];
    assign addrPinOut = pinOut[pc_card_mux_pkg::PIN_ADDR_LSB +: 26];
    assign addrPinOe = pinOe[pc_card_mux_pkg::PIN_ADDR_LSB +: 26];
    assign dataPinOut = pinOut[pc_card_mux_pkg::PIN_DATA_LSB +: 16];
    assign dataPinOe = pinOe[pc_card_mux_pkg::PIN_DATA_LSB +: 16];

endmodule

`default_nettype wire

/* hw/pc_card_mux_pkg.sv */
package pc_card_mux_pkg;

    // Interface personality of one socket
    typedef enum logic [1:0] {
        MODE_MEMORY,
        MODE_IO,
        MODE_ATA,
        MODE_CARDBUS
    } socket_mode_t;

    // Pin group widths
    localparam int ADDR_PINS = 26;
    localparam int DATA_PINS = 16;
    localparam int AD_WIDTH = 32;
    localparam int CBE_WIDTH = 4;
    localparam int CTL_WIDTH = 8;

    // Bit positions inside the CardBus control group
    localparam int CTL_FRAME = 0;
    localparam int CTL_TRDY = 1;
    localparam int CTL_DEVSEL = 2;
    localparam int CTL_STOP = 3;
    localparam int CTL_IRDY = 4;
    localparam int CTL_LOCK = 5;
    localparam int CTL_PERR = 6;
    localparam int CTL_PAR = 7;

    // Layout of the flattened socket pin vector
    localparam int PIN_WIDTH = 44;
    localparam int PIN_DATA_LSB = 0;
    localparam int PIN_ADDR_LSB = 16;
    localparam int PIN_CE1 = 42;
    localparam int PIN_REG = 43;
    localparam int PIN_CCLK = PIN_ADDR_LSB + 16;

    typedef logic [PIN_WIDTH-1:0] pin_vec_t;

    // Values after reset
    localparam socket_mode_t MODE_RESET = MODE_MEMORY;
    localparam logic REG_PIN_RESET = 1'b1;
    localparam logic CE1_PIN_RESET = 1'b1;

    // Depth of the input synchronisers
    localparam int SYNC_STAGES = 3;

endpackage

/* hw/sync_level.sv */
`timescale 1ns/1ps
`default_nettype none

module sync_level #(
    parameter int WIDTH = 1
) (
    // Clock and synchronous reset of the receiving domain
    input wire logic clk,
    input wire logic rstN,
    // Level from another domain and its settled copy
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } sync_state_t;

    sync_state_t st;
    sync_state_t next_st;

    // Stage one feeds stage two only; a change is taken once 2 and 3 agree
    always_comb begin
        next_st = st;
        next_st.s1 = d;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.q[i] = st.s3[i];
            end
        end
        if (!rstN) begin
            next_st = '0;
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    assign q = st.q;

endmodule

`default_nettype wire

/* verif/pc_card_socket_pin_mux_props.sv */
`timescale 1ns/1ps
`default_nettype none

module pc_card_socket_pin_mux_props (
    // Clocks and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic cardClk,
    // Steering inputs
    input wire pc_card_mux_pkg::socket_mode_t modeSel,
    input wire logic [25:0] pcAddr,
    input wire logic pcAddrOe,
    input wire logic [15:0] pcDataOut,
    input wire logic pcDataOe,
    input wire logic pcAttrSel,
    input wire logic pcDma,
    input wire logic cbActive,
    // Socket pins
    input wire logic regPinOut,
    input wire logic regPinOe,
    input wire logic ce1PinOe,
    input wire logic [25:0] addrPinOut,
    input wire logic [25:0] addrPinOe,
    input wire logic [15:0] dataPinOut,
    input wire logic [15:0] dataPinOe
);
    default clocking sysCk @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // Mode taken one edge ago; invalid right after reset
    logic prevOk;
    pc_card_mux_pkg::socket_mode_t prevMode;
    always_ff @(posedge sys_clk) begin
        prevOk <= reset_n;
        prevMode <= modeSel;
    end
    logic isMem, isIo, isAta, isCb, is16;
    assign isMem = prevOk && prevMode == pc_card_mux_pkg::MODE_MEMORY;
    assign isIo = prevOk && prevMode == pc_card_mux_pkg::MODE_IO;
    assign isAta = prevOk && prevMode == pc_card_mux_pkg::MODE_ATA;
    assign isCb = prevOk && prevMode == pc_card_mux_pkg::MODE_CARDBUS;
    assign is16 = isMem || isIo || isAta;

    property p_attr;
        isMem |-> regPinOut == !$past(pcAttrSel);
    endproperty
    a_attr: assert property (p_attr)
        else $error("attribute select wrong");
    property p_dma;
        isIo |-> regPinOut == $past(pcDma);
    endproperty
    a_dma: assert property (p_dma)
        else $error("dma select wrong");
    property p_ata;
        isAta [*2] |-> regPinOut && $stable(regPinOut);
    endproperty
    a_ata: assert property (p_ata)
        else $error("ata select not high");
    property p_addr16;
        is16 |-> addrPinOut == $past(pcAddr)
            && addrPinOe == {26{$past(pcAddrOe)}};
    endproperty
    a_addr16: assert property (p_addr16)
        else $error("address pins mixed");
    property p_data16;
        is16 |-> dataPinOut == $past(pcDataOut)
            && dataPinOe == {16{$past(pcDataOe)}};
    endproperty
    a_data16: assert property (p_data16)
        else $error("data pins mixed");
    property p_cclk;
        isCb |-> addrPinOut[16] == cardClk && addrPinOe[16];
    endproperty
    a_cclk: assert property (p_cclk)
        else $error("card clock pin wrong");
    property p_rsv;
        isCb |-> !addrPinOut[18] && addrPinOe[18]
            && !dataPinOe[14] && !dataPinOe[2];
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("reserved pin driven");
    property p_gate;
        isCb && !cbActive |-> dataPinOe == 16'h0000 && !regPinOe;
    endproperty
    a_gate: assert property (p_gate)
        else $error("drive before link active");
    property p_lanes;
        isCb |-> ce1PinOe == regPinOe;
    endproperty
    a_lanes: assert property (p_lanes)
        else $error("byte lane enables split");

    // Main scenarios reached
    c_active: cover property ($rose(cbActive));
    c_dma: cover property (isIo && regPinOut);
    c_attr: cover property (isMem && !regPinOut);
endmodule

`default_nettype wire

/* verif/card_socket_model.sv */
`timescale 1ns/1ps
`default_nettype none

module card_socket_model (
    // Device drive of the socket pins, packed reg, ce1, addr, data
    input wire pc_card_mux_pkg::pin_vec_t devOut,
    input wire pc_card_mux_pkg::pin_vec_t devOe,
    // Card drive of the same pins
    input wire pc_card_mux_pkg::pin_vec_t cardPins,
    input wire pc_card_mux_pkg::pin_vec_t cardOe,
    // Level seen on each pin
    output logic [pc_card_mux_pkg::PIN_WIDTH-1:0] level
);
    // Floating or fought-over pins flip, so a stale value never passes
    assign level = (devOe & ~cardOe & devOut)
        | (~devOe & cardOe & cardPins)
        | ((devOe ~^ cardOe) & ~devOut);
endmodule

`default_nettype wire

/* verif/test_pc_card_socket_pin_mux.sv */
`timescale 1ns/1ps
`default_nettype none

module test_pc_card_socket_pin_mux;
    // Stimulus, set at time zero
    logic sys_clk = 1'b0;
    logic cardClk = 1'b0;
    logic reset_n = 1'b0;
    pc_card_mux_pkg::socket_mode_t modeSel = pc_card_mux_pkg::MODE_MEMORY;
    logic [25:0] pcAddr = 26'h0000000;
    logic [15:0] pcDataOut = 16'h0000;
    logic pcAddrOe = 1'b0, pcDataOe = 1'b0, pcAttrSel = 1'b0;
    logic pcDma = 1'b0, pcCe1Out = 1'b1, pcCe1Oe = 1'b0;
    logic [31:0] cbAdOut = 32'h00000000;
    logic [3:0] cbCbeOut = 4'h0;
    logic [7:0] cbCtlOut = 8'h00, cbCtlOe = 8'h00;
    logic cbAdOe = 1'b0, cbCbeOe = 1'b0;
    pc_card_mux_pkg::pin_vec_t cardPins = 44'h0, cardOe = 44'h0;
    // Observed
    logic [15:0] pcDataIn, dataPinOut, dataPinOe, dataPinIn;
    logic [31:0] cbAdIn;
    logic [3:0] cbCbeIn;
    logic [7:0] cbCtlIn;
    logic cbActive, regPinOut, regPinOe, regPinIn;
    logic ce1PinOut, ce1PinOe, ce1PinIn;
    logic [25:0] addrPinOut, addrPinOe, addrPinIn;
    pc_card_mux_pkg::pin_vec_t pinsOut, pinsOe;
    int error_cnt = 0;
    int comparisons = 0;
    assign pinsOut = {regPinOut, ce1PinOut, addrPinOut, dataPinOut};
    assign pinsOe = {regPinOe, ce1PinOe, addrPinOe, dataPinOe};

    // Link clock offset so its edges never meet the system clock
    always #4 sys_clk = ~sys_clk;
    initial begin
        #3.3;
        forever #24 cardClk = ~cardClk;
    end

    pc_card_socket_pin_mux dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .cardClk(cardClk),
        .modeSel(modeSel), .pcAddr(pcAddr), .pcAddrOe(pcAddrOe),
        .pcDataOut(pcDataOut), .pcDataOe(pcDataOe), .pcDataIn(pcDataIn),
        .pcAttrSel(pcAttrSel), .pcDma(pcDma), .pcCe1Out(pcCe1Out),
        .pcCe1Oe(pcCe1Oe), .cbActive(cbActive), .cbAdOut(cbAdOut),
        .cbAdOe(cbAdOe), .cbAdIn(cbAdIn), .cbCbeOut(cbCbeOut),
        .cbCbeOe(cbCbeOe), .cbCbeIn(cbCbeIn), .cbCtlOut(cbCtlOut),
        .cbCtlOe(cbCtlOe), .cbCtlIn(cbCtlIn), .regPinOut(regPinOut),
        .regPinOe(regPinOe), .regPinIn(regPinIn), .ce1PinOut(ce1PinOut),
        .ce1PinOe(ce1PinOe), .ce1PinIn(ce1PinIn),
        .addrPinOut(addrPinOut), .addrPinOe(addrPinOe),
        .addrPinIn(addrPinIn), .dataPinOut(dataPinOut),
        .dataPinOe(dataPinOe), .dataPinIn(dataPinIn)
    );
    card_socket_model card (
        .devOut(pinsOut), .devOe(pinsOe), .cardPins(cardPins),
        .cardOe(cardOe), .level({regPinIn, ce1PinIn, addrPinIn, dataPinIn})
    );

    // Socket pin image of one CardBus beat, clock pin left at 0
    function automatic pc_card_mux_pkg::pin_vec_t cb_pins(
        input logic [31:0] a, input logic [3:0] e, input logic [7:0] c);
        return {e[3], e[0], a[19], a[17], c[0], c[1], c[2], c[3], c[5],
            1'b0, a[16], 1'b0, c[4], c[6], c[7], e[2], a[12], a[9], a[14],
            e[1], a[18], a[20], a[21], a[22], a[23], a[24], a[25], a[26],
            a[8], 1'b0, a[6], a[4], a[2], a[31], a[30], a[28], a[7], a[5],
            a[3], a[1], a[0], 1'b0, a[29], a[27]};
    endfunction

    task automatic check(input pc_card_mux_pkg::pin_vec_t seen,
        input pc_card_mux_pkg::pin_vec_t exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic ctick(input int n);
        repeat (n) @(posedge cardClk);
        #1;
    endtask
    task automatic stop_test();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Every 16-bit mode, both select levels, then a card read
    task automatic t_sixteen();
        logic sel;
        for (int k = 0; k < 6; k++) begin
            modeSel = pc_card_mux_pkg::socket_mode_t'(k / 2);
            {pcAttrSel, pcDma, pcCe1Out} = {3{k[0]}};
            {pcAddrOe, pcDataOe, pcCe1Oe} = 3'h7;
            pcAddr = 26'h2a5c3e1 ^ 26'(k);
            pcDataOut = 16'h5a3c ^ 16'(k);
            sel = k < 2 ? !k[0] : k < 4 ? k[0] : 1'b1;
            tick(2);
            check(pinsOut, {sel, pcCe1Out, pcAddr, pcDataOut});
            check(pinsOe, 44'hfffffffffff);
            pcDataOe = 1'b0;
            cardPins = 44'h0000000c3a5 ^ 44'(k);
            cardOe = 44'h0000000ffff;
            tick(6);
            check(44'(pcDataIn), cardPins);
            cardOe = 44'h0;
        end
    endtask

    // Walking ones out through every CardBus leg, walking zeros back in
    task automatic t_cardbus();
        ctick(1);
        {cbAdOe, cbCbeOe, cbCtlOe} = 10'h3ff;
        tick(1);
        modeSel = pc_card_mux_pkg::MODE_CARDBUS;
        tick(2);
        check(pinsOe, 44'h00500000000);
        for (int n = 0; n < 80 && cbActive !== 1'b1; n++) tick(1);
        check(44'(cbActive), 44'h1);
        if (cbActive !== 1'b1) begin
            return;
        end
        for (int i = 0; i < 32; i++) begin
            ctick(1);
            {cbAdOe, cbCbeOe, cbCtlOe} = 10'h3ff;
            cbAdOut = 32'h1 << i;
            cbCbeOut = 4'h1 << (i % 4);
            cbCtlOut = 8'h1 << (i % 8);
            ctick(3);
            check(pinsOut & ~44'h00100004004,
                cb_pins(cbAdOut, cbCbeOut, cbCtlOut));
            check(pinsOe, 44'hfffffffbffb);
            {cbAdOe, cbCbeOe, cbCtlOe} = 10'h000;
            ctick(2);
            cardPins = cb_pins(~cbAdOut, ~cbCbeOut, ~cbCtlOut);
            cardOe = 44'hffaffffffff;
            ctick(3);
            check({cbCtlIn, cbCbeIn, cbAdIn}, {~cbCtlOut, ~cbCbeOut,
                ~cbAdOut & 32'hffff53ff});
            cardOe = 44'h0;
        end
        tick(1);
        modeSel = pc_card_mux_pkg::MODE_MEMORY;
        tick(2);
        check(pinsOut, {!pcAttrSel, pcCe1Out, pcAddr, pcDataOut});
    endtask

    // Long reset so the link-side synchroniser clears too
    initial begin
        repeat (32) @(posedge sys_clk);
        #1;
        reset_n = 1'b1;
        t_sixteen();
        t_cardbus();
        stop_test();
    end
endmodule

bind pc_card_socket_pin_mux pc_card_socket_pin_mux_props props (
    .sys_clk(sys_clk), .reset_n(reset_n), .cardClk(cardClk),
    .modeSel(modeSel), .pcAddr(pcAddr), .pcAddrOe(pcAddrOe),
    .pcDataOut(pcDataOut), .pcDataOe(pcDataOe), .pcAttrSel(pcAttrSel),
    .pcDma(pcDma), .cbActive(cbActive), .regPinOut(regPinOut),
    .regPinOe(regPinOe), .ce1PinOe(ce1PinOe), .addrPinOut(addrPinOut),
    .addrPinOe(addrPinOe), .dataPinOut(dataPinOut), .dataPinOe(dataPinOe)
);

`default_nettype wire
